// file: verilog/usb_ep_pkg.sv
// Purpose: Shared constants and helpers for the USB endpoint control block
// Assumes: AXI4-Lite register bus, 32-bit data, 8-bit byte address
// Notes:   Register offsets are byte addresses, one aligned word each
`default_nettype none
package usb_ep_pkg;
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam int unsigned ADDR_W       = 8;
    localparam int unsigned EP_COUNT     = 16;
    localparam logic [7:0] EP_BASE_OFS   = 8'h00;  // Endpoint n at 4*n
    localparam logic [7:0] IRQ_STAT_OFS  = 8'h40;
    localparam logic [7:0] IRQ_MASK_OFS  = 8'h44;
    localparam logic [7:0] HOST_CTRL_OFS = 8'h48;
    // ------------------------------------------------------------
    // Endpoint control fields
    // ------------------------------------------------------------
    localparam int unsigned LOW_SPEED_DIRECT_BIT = 7;
    localparam int unsigned NAK_RETRY_DIS_BIT    = 6;
    localparam int unsigned CTRL_XFER_DIS_BIT    = 4;
    localparam int unsigned RX_EN_BIT            = 3;
    localparam int unsigned TX_EN_BIT            = 2;
    localparam int unsigned STALLED_BIT          = 1;
    localparam int unsigned HANDSHAKE_BIT        = 0;
    localparam logic [7:0]  CTRL_IMPL_MASK       = 8'hdf;
    localparam logic [7:0]  CTRL_RESET           = 8'h00;
    // ------------------------------------------------------------
    // Interrupt, host control and bus answers
    // ------------------------------------------------------------
    localparam int unsigned IRQ_W          = 2;
    localparam int unsigned IRQ_STALL_BIT  = 0;
    localparam int unsigned IRQ_REJECT_BIT = 1;
    localparam int unsigned HOST_MODE_BIT  = 0;
    localparam logic [1:0]  RESP_OKAY      = 2'h0;
    localparam logic [1:0]  RESP_SLVERR    = 2'h2;

    typedef enum logic [1:0] {
        TOK_OUT   = 2'h1,
        TOK_IN    = 2'h2,
        TOK_SETUP = 2'h3
    } token_kind_e;

    // Word aligned and inside the map
    function automatic logic addr_ok(input logic [7:0] a);
        return (a[1:0] == 2'h0) && (a <= HOST_CTRL_OFS);
    endfunction

    // Endpoint slot of an endpoint-register address
    function automatic logic [3:0] ep_index(input logic [7:0] a);
        return a[5:2];
    endfunction
endpackage
`default_nettype wire

// file: verilog/axil_slave.sv
// Purpose: AXI4-Lite slave front end, one write and one read in flight
// Assumes: Master holds valid and payload until taken
// Notes:   wr_en and rd_en are one-cycle strobes toward the register file
`timescale 1ns/100ps
`default_nettype none
module axil_slave (
    // Clock and reset
    input  wire logic                         aclk,
    input  wire logic                         aresetn,
    // AXI4-Lite
    input  wire logic [usb_ep_pkg::ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                         s_axi_awvalid,
    output logic                              s_axi_awready,
    input  wire logic [31:0]                  s_axi_wdata,
    input  wire logic [3:0]                   s_axi_wstrb,
    input  wire logic                         s_axi_wvalid,
    output logic                              s_axi_wready,
    output logic [1:0]                        s_axi_bresp,
    output logic                              s_axi_bvalid,
    input  wire logic                         s_axi_bready,
    input  wire logic [usb_ep_pkg::ADDR_W-1:0] s_axi_araddr,
    input  wire logic                         s_axi_arvalid,
    output logic                              s_axi_arready,
    output logic [31:0]                       s_axi_rdata,
    output logic [1:0]                        s_axi_rresp,
    output logic                              s_axi_rvalid,
    input  wire logic                         s_axi_rready,
    // Register file side
    output logic                              wr_en,
    output logic [usb_ep_pkg::ADDR_W-1:0]     wr_addr,
    output logic [31:0]                       wr_data,
    output logic [3:0]                        wr_strb,
    output logic                              rd_en,
    output logic [usb_ep_pkg::ADDR_W-1:0]     rd_addr,
    input  wire logic [31:0]                  rd_data
);
    import usb_ep_pkg::*;

    typedef struct packed {
        logic              awready;
        logic              wready;
        logic              arready;
        logic              aw_have;
        logic              w_have;
        logic [ADDR_W-1:0] waddr;
        logic [31:0]       wdata;
        logic [3:0]        wstrb;
        logic              bvalid;
        logic [1:0]        bresp;
        logic              ar_have;
        logic [ADDR_W-1:0] raddr;
        logic              rvalid;
        logic [31:0]       rdata;
        logic [1:0]        rresp;
    } axil_s;

    axil_s q, d;

    // Write strobe fires once both halves are held, read strobe once the address is, each with its answer slot free
    assign wr_en   = q.aw_have && q.w_have && !q.bvalid;
    assign wr_addr = q.waddr;
    assign wr_data = q.wdata;
    assign wr_strb = q.wstrb;
    assign rd_en   = q.ar_have && !q.rvalid;
    assign rd_addr = q.raddr;

    // Next state; readies follow next state so they are plain flops
    always_comb begin
        d = q;
        if (s_axi_awvalid && q.awready) begin
            d.aw_have = 1'b1;
            d.waddr   = s_axi_awaddr;
        end
        if (s_axi_wvalid && q.wready) begin
            d.w_have = 1'b1;
            d.wdata  = s_axi_wdata;
            d.wstrb  = s_axi_wstrb;
        end
        if (q.bvalid && s_axi_bready) begin
            d.bvalid = 1'b0;
        end
        if (wr_en) begin
            d.aw_have = 1'b0;
            d.w_have  = 1'b0;
            d.bvalid  = 1'b1;
            d.bresp   = addr_ok(q.waddr) ? RESP_OKAY : RESP_SLVERR;
        end
        if (s_axi_arvalid && q.arready) begin
            d.ar_have = 1'b1;
            d.raddr   = s_axi_araddr;
        end
        if (q.rvalid && s_axi_rready) begin
            d.rvalid = 1'b0;
        end
        if (rd_en) begin
            d.ar_have = 1'b0;
            d.rvalid  = 1'b1;
            d.rdata   = rd_data;
            d.rresp   = addr_ok(q.raddr) ? RESP_OKAY : RESP_SLVERR;
        end
        d.awready = !d.aw_have && !d.bvalid;
        d.wready  = !d.w_have && !d.bvalid;
        d.arready = !d.ar_have && !d.rvalid;
    end

    // State register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign s_axi_awready = q.awready;
    assign s_axi_wready  = q.wready;
    assign s_axi_bvalid  = q.bvalid;
    assign s_axi_bresp   = q.bresp;
    assign s_axi_arready = q.arready;
    assign s_axi_rvalid  = q.rvalid;
    assign s_axi_rdata   = q.rdata;
    assign s_axi_rresp   = q.rresp;
endmodule // axil_slave
`default_nettype wire

// file: verilog/ep_token_policy.sv
// Purpose: Decides per token whether an endpoint takes part, and how
// Assumes: Caller presents the addressed endpoint's control byte
// Notes:   Answer is registered, one cycle after the token strobe
`timescale 1ns/100ps
`default_nettype none
module ep_token_policy (
    // Clock and reset
    input  wire logic                    aclk,
    input  wire logic                    aresetn,
    // Token in
    input  wire logic                    tok_valid,
    input  wire logic [3:0]              tok_ep,
    input  wire usb_ep_pkg::token_kind_e tok_kind,
    input  wire logic [7:0]              ep_ctrl,
    input  wire logic                    host_mode,
    // Answer out
    output logic                         ans_valid,
    output logic                         ans_accept,
    output logic                         ans_handshake,
    output logic                         ans_low_speed_direct,
    output logic                         ans_nak_retry,
    output logic                         ans_reject
);
    import usb_ep_pkg::*;

    typedef struct packed {
        logic valid;
        logic accept;
        logic handshake;
        logic low_speed_direct;
        logic nak_retry;
        logic reject;
    } ans_s;

    ans_s q, d;
    logic rx_en, tx_en, both_en, host_ep0, acc;

    assign rx_en    = ep_ctrl[RX_EN_BIT];
    assign tx_en    = ep_ctrl[TX_EN_BIT];
    assign both_en  = rx_en && tx_en;
    assign host_ep0 = host_mode && (tok_ep == 4'h0);

    // Token qualification per direction
    always_comb begin
        unique case (tok_kind)
            TOK_OUT:   acc = rx_en;                                     // R5
            TOK_IN:    acc = tx_en;                                     // R6
            // Control disable only counts with both directions on
            TOK_SETUP: acc = rx_en && !(both_en && ep_ctrl[CTRL_XFER_DIS_BIT]); // R3 R4
            default:   acc = 1'b0;
        endcase
        d                  = '0;
        d.valid            = tok_valid;
        d.accept           = tok_valid && acc;
        d.handshake        = tok_valid && acc && ep_ctrl[HANDSHAKE_BIT]; // R8
        d.low_speed_direct = tok_valid && host_ep0 && ep_ctrl[LOW_SPEED_DIRECT_BIT]; // R1
        d.nak_retry        = tok_valid && host_ep0 && !ep_ctrl[NAK_RETRY_DIS_BIT];   // R2
        d.reject           = tok_valid && !acc;
    end

    // Answer register, cleared between tokens
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign ans_valid            = q.valid;
    assign ans_accept           = q.accept;
    assign ans_handshake        = q.handshake;
    assign ans_low_speed_direct = q.low_speed_direct;
    assign ans_nak_retry        = q.nak_retry;
    assign ans_reject           = q.reject;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_out_needs_rx;
        tok_valid && tok_kind == TOK_OUT |=> ans_valid && ans_accept == $past(rx_en);
    endproperty
    a_out_needs_rx: assert property (p_out_needs_rx) else $error("OUT accept wrong"); // R5
    property p_in_needs_tx;
        tok_valid && tok_kind == TOK_IN |=> ans_accept == $past(tx_en);
    endproperty
    a_in_needs_tx: assert property (p_in_needs_tx) else $error("IN accept wrong"); // R6
    property p_setup_blocked;
        tok_valid && tok_kind == TOK_SETUP && both_en && ep_ctrl[CTRL_XFER_DIS_BIT] |=> !ans_accept && ans_reject;
    endproperty
    a_setup_blocked: assert property (p_setup_blocked) else $error("SETUP not refused"); // R3
    property p_setup_disable_ignored;
        tok_valid && tok_kind == TOK_SETUP && rx_en && !tx_en |=> ans_accept;
    endproperty
    a_setup_disable_ignored: assert property (p_setup_disable_ignored) else $error("SETUP wrongly refused"); // R4
    property p_no_handshake;
        tok_valid && !ep_ctrl[HANDSHAKE_BIT] |=> ans_valid && !ans_handshake;
    endproperty
    a_no_handshake: assert property (p_no_handshake) else $error("Handshake while off"); // R8
    property p_ls_only_ep0;
        tok_valid && tok_ep != 4'h0 |=> !ans_low_speed_direct && !ans_nak_retry;
    endproperty
    a_ls_only_ep0: assert property (p_ls_only_ep0) else $error("Host bits off endpoint 0"); // R1
    property p_retry_on;
        tok_valid && host_ep0 && !ep_ctrl[NAK_RETRY_DIS_BIT] |=> ans_nak_retry;
    endproperty
    a_retry_on: assert property (p_retry_on) else $error("Retry not offered"); // R2

    c_setup_taken: cover property (tok_valid && tok_kind == TOK_SETUP ##1 ans_accept);
    c_iso_in: cover property (tok_valid && tok_kind == TOK_IN ##1 ans_accept && !ans_handshake);
endmodule // ep_token_policy
`default_nettype wire

// file: verilog/usb_endpoint_control.sv
// Purpose: Sixteen USB endpoint control registers and token policy
// Assumes: Link logic presents tokens and stall events on aclk
// Notes:   Software reaches all registers over AXI4-Lite
//
// Notes on behaviour
// R1: Host mode, endpoint 0: low-speed direct bit allows talking without hub.
// R2: Host mode, endpoint 0: retry-disable bit stops hardware retrying NAKed transactions.
// R3: Both directions enabled: control-disable bit rejects SETUP, data transfers still allowed.
// R4: Control-disable bit is ignored unless receive and transmit are both enabled.
// R5: Receive-enable bit lets the endpoint accept received data.
// R6: Transmit-enable bit lets the endpoint send data.
// R7: Stalled flag is set by hardware when the endpoint has stalled.
// R8: Handshake-enable bit lets the endpoint send handshakes; off for isochronous.
// R9: Bits 31..8 and bit 5 of each endpoint register read zero.
// R10: Sixteen endpoint registers, every implemented field resets to zero.
`timescale 1ns/100ps
`default_nettype none
module usb_endpoint_control (
    // Clock and reset
    input  wire logic                          aclk,
    input  wire logic                          aresetn,
    // AXI4-Lite write
    input  wire logic [usb_ep_pkg::ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                          s_axi_awvalid,
    output logic                               s_axi_awready,
    input  wire logic [31:0]                   s_axi_wdata,
    input  wire logic [3:0]                    s_axi_wstrb,
    input  wire logic                          s_axi_wvalid,
    output logic                               s_axi_wready,
    output logic [1:0]                         s_axi_bresp,
    output logic                               s_axi_bvalid,
    input  wire logic                          s_axi_bready,
    // AXI4-Lite read
    input  wire logic [usb_ep_pkg::ADDR_W-1:0] s_axi_araddr,
    input  wire logic                          s_axi_arvalid,
    output logic                               s_axi_arready,
    output logic [31:0]                        s_axi_rdata,
    output logic [1:0]                         s_axi_rresp,
    output logic                               s_axi_rvalid,
    input  wire logic                          s_axi_rready,
    // Token from link logic
    input  wire logic                          tok_valid,
    input  wire logic [3:0]                    tok_ep,
    input  wire usb_ep_pkg::token_kind_e       tok_kind,
    // Stall event from link logic
    input  wire logic                          stall_valid,
    input  wire logic [3:0]                    stall_ep,
    // Token answer
    output logic                               ans_valid,
    output logic                               ans_accept,
    output logic                               ans_handshake,
    output logic                               ans_low_speed_direct,
    output logic                               ans_nak_retry,
    // Mode and interrupt
    output logic                               host_mode,
    output logic                               irq
);
    import usb_ep_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [EP_COUNT-1:0][7:0] ctrl;
        logic [IRQ_W-1:0]         irq_stat;
        logic [IRQ_W-1:0]         irq_mask;
        logic                     host_mode;
        logic                     irq;
    } regs_s;

    regs_s q, d;

    logic              wr_en;
    logic [ADDR_W-1:0] wr_addr;
    logic [31:0]       wr_data;
    logic [3:0]        wr_strb;
    logic              rd_en;
    logic [ADDR_W-1:0] rd_addr;
    logic [31:0]       rd_data;
    logic              ans_reject;
    logic              wr_ep;
    logic              rd_ep;

    // Endpoint window decode
    assign wr_ep = wr_addr[1:0] == 2'h0 && wr_addr < IRQ_STAT_OFS;
    assign rd_ep = rd_addr[1:0] == 2'h0 && rd_addr < IRQ_STAT_OFS;

    // ------------------------------------------------------------
    // Bus front end
    // ------------------------------------------------------------
    axil_slave u_bus (
        .aclk          (aclk),
        .aresetn       (aresetn),
        .s_axi_awaddr  (s_axi_awaddr),
        .s_axi_awvalid (s_axi_awvalid),
        .s_axi_awready (s_axi_awready),
        .s_axi_wdata   (s_axi_wdata),
        .s_axi_wstrb   (s_axi_wstrb),
        .s_axi_wvalid  (s_axi_wvalid),
        .s_axi_wready  (s_axi_wready),
        .s_axi_bresp   (s_axi_bresp),
        .s_axi_bvalid  (s_axi_bvalid),
        .s_axi_bready  (s_axi_bready),
        .s_axi_araddr  (s_axi_araddr),
        .s_axi_arvalid (s_axi_arvalid),
        .s_axi_arready (s_axi_arready),
        .s_axi_rdata   (s_axi_rdata),
        .s_axi_rresp   (s_axi_rresp),
        .s_axi_rvalid  (s_axi_rvalid),
        .s_axi_rready  (s_axi_rready),
        .wr_en         (wr_en),
        .wr_addr       (wr_addr),
        .wr_data       (wr_data),
        .wr_strb       (wr_strb),
        .rd_en         (rd_en),
        .rd_addr       (rd_addr),
        .rd_data       (rd_data)
    );

    // ------------------------------------------------------------
    // Token policy
    // ------------------------------------------------------------
    ep_token_policy u_policy (
        .aclk                 (aclk),
        .aresetn              (aresetn),
        .tok_valid            (tok_valid),
        .tok_ep               (tok_ep),
        .tok_kind             (tok_kind),
        .ep_ctrl              (q.ctrl[tok_ep]),
        .host_mode            (q.host_mode),
        .ans_valid            (ans_valid),
        .ans_accept           (ans_accept),
        .ans_handshake        (ans_handshake),
        .ans_low_speed_direct (ans_low_speed_direct),
        .ans_nak_retry        (ans_nak_retry),
        .ans_reject           (ans_reject)
    );

    // ------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------
    // Reserved bits come back zero from the mask and zero extension
    always_comb begin
        rd_data = 32'h0000_0000;
        if (rd_ep) begin
            rd_data[7:0] = q.ctrl[ep_index(rd_addr)] & CTRL_IMPL_MASK; // R9
        end else if (rd_addr == IRQ_STAT_OFS) begin
            rd_data[IRQ_W-1:0] = q.irq_stat;
        end else if (rd_addr == IRQ_MASK_OFS) begin
            rd_data[IRQ_W-1:0] = q.irq_mask;
        end else if (rd_addr == HOST_CTRL_OFS) begin
            rd_data[HOST_MODE_BIT] = q.host_mode;
        end
    end

    // ------------------------------------------------------------
    // Register update
    // ------------------------------------------------------------
    // Software writes first, hardware events last so a set beats a clear
    always_comb begin
        d = q;
        if (wr_en && wr_strb[0]) begin
            if (wr_ep) begin
                d.ctrl[ep_index(wr_addr)] = wr_data[7:0] & CTRL_IMPL_MASK; // R9
            end else if (wr_addr == IRQ_MASK_OFS) begin
                d.irq_mask = wr_data[IRQ_W-1:0];
            end else if (wr_addr == HOST_CTRL_OFS) begin
                d.host_mode = wr_data[HOST_MODE_BIT];
            end
        end
        // Reading the status word consumes it
        if (rd_en && rd_addr == IRQ_STAT_OFS) begin
            d.irq_stat = '0;
        end
        if (stall_valid) begin
            d.ctrl[stall_ep][STALLED_BIT] = 1'b1; // R7
            d.irq_stat[IRQ_STALL_BIT]     = 1'b1;
        end
        if (ans_reject) begin
            d.irq_stat[IRQ_REJECT_BIT] = 1'b1;
        end
        d.irq = |(d.irq_stat & d.irq_mask);
    end

    // State register, everything zero after reset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q <= '0; // R10
        end else begin
            q <= d;
        end
    end

    assign host_mode = q.host_mode;
    assign irq       = q.irq;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_stall_sets_flag;
        stall_valid |=> q.ctrl[$past(stall_ep)][STALLED_BIT] && q.irq_stat[IRQ_STALL_BIT];
    endproperty
    a_stall_sets_flag: assert property (p_stall_sets_flag) else $error("Stall flag not set"); // R7

    property p_reserved_read_zero;
        rd_en && rd_ep |=> s_axi_rvalid && s_axi_rdata[31:8] == 24'h00_0000 && !s_axi_rdata[5];
    endproperty
    a_reserved_read_zero: assert property (p_reserved_read_zero) else $error("Reserved bits not zero"); // R9

    property p_write_lands;
        wr_en && wr_strb[0] && wr_ep && !stall_valid
            |=> q.ctrl[$past(ep_index(wr_addr))] == ($past(wr_data[7:0]) & CTRL_IMPL_MASK);
    endproperty
    a_write_lands: assert property (p_write_lands) else $error("Endpoint write lost"); // R9

    property p_reset_clears;
        @(posedge aclk) $rose(aresetn) |-> q.ctrl == '0 && !irq && !ans_valid;
    endproperty
    a_reset_clears: assert property (p_reset_clears) else $error("Not clear after reset"); // R10

    property p_irq_follows;
        stall_valid && q.irq_mask[IRQ_STALL_BIT] && !wr_en |=> irq;
    endproperty
    a_irq_follows: assert property (p_irq_follows) else $error("Interrupt missing");

    c_stall_irq: cover property (stall_valid ##1 irq);
    c_status_read: cover property (rd_en && rd_addr == IRQ_STAT_OFS && q.irq_stat != '0);
    c_ep15_write: cover property (wr_en && wr_ep && ep_index(wr_addr) == 4'hf);
endmodule // usb_endpoint_control
`default_nettype wire

// file: dv/usb_link_model.sv
// Purpose: USB link side, turns bench commands into token and stall pulses
// Assumes: One command per call, held for one cycle
// Notes:   Idle fields toggle so no one leans on stale values
`timescale 1ns/100ps
`default_nettype none
module usb_link_model (
    // Clock
    input  wire logic                    aclk,
    // Bench commands
    input  wire logic                    go_tok,
    input  wire logic                    go_stall,
    input  wire logic [3:0]              c_ep,
    input  wire usb_ep_pkg::token_kind_e c_kind,
    // Toward the endpoint block
    output logic                         tok_valid,
    output logic [3:0]                   tok_ep,
    output usb_ep_pkg::token_kind_e      tok_kind,
    output logic                         stall_valid,
    output logic [3:0]                   stall_ep
);
    import usb_ep_pkg::*;
    // One-cycle pulses, fields inverted between events
    always_ff @(posedge aclk) begin
        tok_valid   <= go_tok;
        stall_valid <= go_stall;
        tok_ep      <= go_tok ? c_ep : ~tok_ep;
        tok_kind    <= go_tok ? c_kind : token_kind_e'(~tok_kind);
        stall_ep    <= go_stall ? c_ep : ~stall_ep;
    end
endmodule // usb_link_model
`default_nettype wire

// file: dv/usb_endpoint_control_tb.sv
// Purpose: Random and corner checks of the endpoint control block
// Assumes: Bus tasks start just after a clock edge
// Notes:   Expected answers come from bench functions
`timescale 1ns/100ps
`default_nettype none
module usb_endpoint_control_tb;
    import usb_ep_pkg::*;
    logic aclk = 1'b0, aresetn = 1'b0, aw_v = '0, w_v = '0, b_r = '0, ar_v = '0, r_r = '0, go_tok = '0, go_stall = '0;
    logic aw_r, w_r, b_v, ar_r, r_v, tok_valid, stall_valid, a_v, a_acc, a_hs, a_lsd, a_nr, host_mode, irq, h;
    logic [7:0] aw_a = 8'h0, ar_a = 8'h0, c;
    logic [31:0] w_d = 32'h0, r_d, w, d;
    logic [1:0] b_resp, r_resp, r;
    logic [3:0] c_ep = 4'h0, tok_ep, stall_ep, e;
    token_kind_e c_kind = TOK_OUT, tok_kind, k;
    int miscompares = 0, total_checks = 0, i;
    // Clock, 10 ns period
    always #5 aclk = ~aclk;
    usb_endpoint_control i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(aw_a), .s_axi_awvalid(aw_v),
        .s_axi_awready(aw_r), .s_axi_wdata(w_d), .s_axi_wstrb(4'hf), .s_axi_wvalid(w_v), .s_axi_wready(w_r),
        .s_axi_bresp(b_resp), .s_axi_bvalid(b_v), .s_axi_bready(b_r), .s_axi_araddr(ar_a), .s_axi_arvalid(ar_v),
        .s_axi_arready(ar_r), .s_axi_rdata(r_d), .s_axi_rresp(r_resp), .s_axi_rvalid(r_v), .s_axi_rready(r_r),
        .tok_valid(tok_valid), .tok_ep(tok_ep), .tok_kind(tok_kind), .stall_valid(stall_valid),
        .stall_ep(stall_ep), .ans_valid(a_v), .ans_accept(a_acc), .ans_handshake(a_hs),
        .ans_low_speed_direct(a_lsd), .ans_nak_retry(a_nr), .host_mode(host_mode), .irq(irq));
    usb_link_model i_link (.aclk(aclk), .go_tok(go_tok), .go_stall(go_stall), .c_ep(c_ep), .c_kind(c_kind),
        .tok_valid(tok_valid), .tok_ep(tok_ep), .tok_kind(tok_kind), .stall_valid(stall_valid), .stall_ep(stall_ep));
    task automatic chk(input string n, input logic [31:0] x, input logic [31:0] s);
        total_checks++;
        if (s !== x) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", n, x, s);
        end
    endtask
    // Address and data offered together, each released when taken
    task automatic bus_wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
        aw_a <= a; w_d <= v; aw_v <= 1'b1; w_v <= 1'b1; b_r <= 1'b1;
        fork
            begin do @(posedge aclk); while (aw_r !== 1'b1); aw_v <= 1'b0; end
            begin do @(posedge aclk); while (w_r !== 1'b1); w_v <= 1'b0; end
        join
        do @(posedge aclk); while (b_v !== 1'b1);
        rs = b_resp;
    endtask
    task automatic bus_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
        ar_a <= a; ar_v <= 1'b1; r_r <= 1'b1;
        do @(posedge aclk); while (ar_r !== 1'b1);
        ar_v <= 1'b0;
        do @(posedge aclk); while (r_v !== 1'b1);
        v = r_d;
        rs = r_resp;
    endtask
    // Link event, answer checked while it stands
    task automatic fire(input logic s, input logic [3:0] p, input token_kind_e q);
        go_tok <= !s; go_stall <= s; c_ep <= p; c_kind <= q;
        @(posedge aclk);
        go_tok <= 1'b0; go_stall <= 1'b0;
        @(posedge aclk);
        #1;
    endtask
    function automatic logic [4:0] exp_ans(logic [7:0] f, logic [3:0] p, token_kind_e q, logic hm);
        logic acc;
        acc = (q == TOK_OUT) ? f[3] : (q == TOK_IN) ? f[2] : f[3] & !(f[3] & f[2] & f[4]);
        return {1'b1, acc, acc & f[0], hm & (p == 4'h0) & f[7], hm & (p == 4'h0) & !f[6]};
    endfunction
    task automatic end_sim();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // Watchdog, far beyond the expected run
    initial begin
        #300000;
        miscompares++;
        end_sim();
    end
    initial begin
        void'($urandom(29));
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        for (i = 0; i < 16; i++) begin
            bus_rd(8'(4 * i), d, r);
            chk("reset", 32'h0, d);
            w = $urandom & 32'hffff_fffd;
            bus_wr(8'(4 * i), w, r);
            bus_rd(8'(4 * i), d, r);
            chk("ctrl", w & 32'hdf, d);
        end
        $display("test registers done");
        // Device mode first half, host mode second half
        for (i = 0; i < 96; i++) begin
            h = (i >= 48);
            if (i % 48 == 0) bus_wr(HOST_CTRL_OFS, {31'h0, h}, r);
            e = (i % 3 == 0) ? 4'h0 : 4'($urandom);
            c = 8'($urandom) & 8'hdd;
            k = token_kind_e'(2'($urandom % 3 + 1));
            bus_wr(8'(4 * e), {24'h0, c}, r);
            fire(1'b0, e, k);
            chk("answer", 32'({exp_ans(c, e, k, h), h}),
                32'({a_v, a_acc, a_hs, a_lsd, a_nr, host_mode}));
        end
        $display("test tokens done");
        bus_wr(IRQ_MASK_OFS, 32'h1, r);
        bus_wr(8'h14, 32'h0, r);
        fire(1'b1, 4'h5, TOK_OUT);
        chk("irq", 32'h1, 32'(irq));
        bus_rd(8'h14, d, r);
        chk("stalled", 32'h2, d);
        bus_rd(IRQ_STAT_OFS, d, r);
        chk("status", 32'h3, d);
        bus_rd(IRQ_STAT_OFS, d, r);
        chk("cleared", 32'h0, {d[30:0], irq});
        bus_wr(IRQ_MASK_OFS, 32'h0, r);
        fire(1'b1, 4'h5, TOK_IN);
        chk("masked", 32'h0, 32'(irq));
        $display("test stall done");
        bus_rd(8'h4c, d, r);
        chk("rresp", 32'(RESP_SLVERR), 32'(r));
        chk("rdata", 32'h0, d);
        bus_wr(8'h80, 32'hff, r);
        chk("bresp", 32'(RESP_SLVERR), 32'(r));
        $display("test unmapped done");
        end_sim();
    end
endmodule // usb_endpoint_control_tb
`default_nettype wire
